// ===== hw/twi_display_slave.sv
// two-wire slave front end of the display driver with strap based self addressing
// assumes scl and sda arrive synchronous to ref_clk and the master keeps scl slow
// enough that each scl level lasts several ref_clk cycles
//
// Function
// - device is slave only, never drives scl
// - sampling keeps up with 3.4 MHz scl
// - master starts transfers only on idle bus
// - sda change during scl high is control
// - both lines high means bus idle
// - sda falling while scl high starts transfer
// - sda rising while scl high ends transfer
// - eight bit bytes plus ninth acknowledge bit
// - acknowledge holds sda low through scl high
// - master adds ninth scl pulse for acknowledge
// - master nack on last read byte, release sda
// - write: acknowledge address and every data byte
// - read: shift bytes out, master acks all but last
// - repeated start restarts with fresh address byte
// - compare address after all eight bits arrive
// - two strap nodes replace two key nodes
// - address zero at startup, one command updates all
// - master repeats self addressing after power loss
// - straps are fixed, no debounce applied
// - select bits low, upper five stay zero
// - last address bit one reads, zero writes
// - acknowledge only a matching address
// - first write byte is register select word

module twi_display_slave
  import twi_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // two-wire bus
  twi_bus_if.slave        bus,
  // strap nodes: high when the node is shorted
  input  wire logic       strap_segment_g_line,
  input  wire logic       strap_segment_f_line,
  // byte supplied for each read byte
  input  wire logic [7:0] read_data,
  // received bytes
  output logic      [7:0] reg_select,
  output logic            select_strobe,
  output logic      [7:0] data_byte,
  output logic            data_strobe,
  output logic            read_strobe,
  // status
  output logic      [6:0] slave_addr,
  output logic            addressed
);

  typedef enum logic [6:0] {
    st_idle    = 7'h01,
    st_addr    = 7'h02,
    st_write   = 7'h04,
    st_ack_out = 7'h08,
    st_read    = 7'h10,
    st_ack_in  = 7'h20,
    st_skip    = 7'h40
  } slave_state_type;

  slave_state_type state;
  logic            scl_q;
  logic            sda_q;
  logic [3:0]      bit_cnt;
  logic [7:0]      shreg;
  logic            dir_read;
  logic            first_data;
  logic            master_ack;
  logic            sda_oe_n;

  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic write_done;
  logic load_read;

  function automatic logic byte_done(input logic [3:0] count);
    return count == BITS_PER_BYTE;
  endfunction

  // open drain: only ever pull low, scl is never driven
  assign bus.slave_sda_o    = 1'h0;
  assign bus.slave_sda_oe_n = sda_oe_n;

  // one sample per ref_clk is ample for the shortest scl phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // any sda edge while scl stays high is a bus condition, not data
  assign start_seen = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_seen  = scl_q & bus.scl & ~sda_q & bus.sda;
  assign scl_rise   = ~scl_q & bus.scl;
  assign scl_fall   = scl_q & ~bus.scl;

  // events that feed the user side; a bus condition in the same cycle wins
  assign write_done = ~start_seen & ~stop_seen & (state == st_write) & scl_fall
                      & byte_done(bit_cnt);
  assign load_read  = ~start_seen & ~stop_seen & scl_fall
                      & (((state == st_ack_out) & dir_read)
                         | ((state == st_ack_in) & master_ack));

  // bus sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state      <= st_idle;
      bit_cnt    <= BIT_COUNT_ZERO;
      shreg      <= 8'h00;
      dir_read   <= 1'h0;
      first_data <= 1'h0;
      master_ack <= 1'h0;
      sda_oe_n   <= 1'h1;
    end else if (start_seen) begin
      // plain or repeated start: drop whatever was going on
      state    <= st_addr;
      bit_cnt  <= BIT_COUNT_ZERO;
      sda_oe_n <= 1'h1;
    end else if (stop_seen) begin
      state    <= st_idle;
      sda_oe_n <= 1'h1;
    end else begin
      case (state)
        st_idle: begin
          // stays here while both lines are high and no start comes
          sda_oe_n <= 1'h1;
        end
        st_addr, st_write: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], bus.sda};
            bit_cnt <= bit_cnt + BIT_COUNT_STEP;
          end else if (scl_fall && byte_done(bit_cnt)) begin
            bit_cnt <= BIT_COUNT_ZERO;
            if (state == st_write) begin
              first_data <= 1'h0;
              sda_oe_n   <= 1'h0;
              state      <= st_ack_out;
            end else if (shreg[7:1] == slave_addr) begin
              dir_read   <= shreg[0] == DIR_READ;
              first_data <= 1'h1;
              sda_oe_n   <= 1'h0;
              state      <= st_ack_out;
            end else begin
              state <= st_skip;
            end
          end
        end
        st_ack_out: begin
          // low was set on the previous fall, so it is stable through scl high
          if (scl_fall) begin
            if (dir_read) begin
              shreg    <= read_data;
              sda_oe_n <= read_data[7];
              state    <= st_read;
            end else begin
              sda_oe_n <= 1'h1;
              state    <= st_write;
            end
          end
        end
        st_read: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + BIT_COUNT_STEP;
          end else if (scl_fall) begin
            if (byte_done(bit_cnt)) begin
              bit_cnt  <= BIT_COUNT_ZERO;
              sda_oe_n <= 1'h1;
              state    <= st_ack_in;
            end else begin
              shreg    <= {shreg[6:0], 1'h0};
              sda_oe_n <= shreg[6];
            end
          end
        end
        st_ack_in: begin
          if (scl_rise) begin
            master_ack <= ~bus.sda;
          end else if (scl_fall) begin
            if (master_ack) begin
              shreg    <= read_data;
              sda_oe_n <= read_data[7];
              state    <= st_read;
            end else begin
              // no acknowledge: leave sda high so the master can stop
              sda_oe_n <= 1'h1;
              state    <= st_skip;
            end
          end
        end
        st_skip: begin
          sda_oe_n <= 1'h1;
        end
        default: begin
          state    <= st_idle;
          sda_oe_n <= 1'h1;
        end
      endcase
    end
  end

  // user side strobes, one cycle each
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_select    <= 8'h00;
      select_strobe <= 1'h0;
      data_byte     <= 8'h00;
      data_strobe   <= 1'h0;
      read_strobe   <= 1'h0;
    end else begin
      select_strobe <= write_done & first_data;
      data_strobe   <= write_done & ~first_data;
      read_strobe   <= load_read;
      if (write_done && first_data) begin
        reg_select <= shreg;
      end
      if (write_done && !first_data) begin
        data_byte <= shreg;
      end
    end
  end

  // self addressing: straps are read once, when the command arrives; no
  // debounce, so they must be fixed wiring rather than keys
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slave_addr <= DEFAULT_ADDR;
    end else if (write_done && first_data && shreg == SELF_ADDR_SELECT) begin
      slave_addr <= {ADDR_UPPER_ZERO, strap_segment_g_line, strap_segment_f_line};
    end
  end

  // status
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addressed <= 1'h0;
    end else begin
      addressed <= (state == st_write) | (state == st_ack_out)
                   | (state == st_read) | (state == st_ack_in);
    end
  end

endmodule

// ===== include/twi_pkg.sv
// shared constants and types for both ends of the two-wire link
// assumes a single 100 MHz reference clock on each end
package twi_pkg;

  // reference clock and fastest bus rate, both in kHz
  localparam int CLK_RATE_KHZ     = 100_000;
  localparam int SCL_MAX_RATE_KHZ = 3_400;
  // a quarter of the shortest scl period, rounded up so the rate never exceeds the maximum
  localparam int SCL_QUARTER_CYCLES =
    (CLK_RATE_KHZ + 4 * SCL_MAX_RATE_KHZ - 1) / (4 * SCL_MAX_RATE_KHZ);

  // addressing
  localparam logic [6:0] DEFAULT_ADDR     = 7'h00;
  localparam logic [4:0] ADDR_UPPER_ZERO  = 5'h00;
  localparam logic [7:0] SELF_ADDR_SELECT = 8'h2d;
  localparam logic       DIR_READ         = 1'h1;

  // byte framing
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_COUNT_STEP = 4'h1;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // byte-level commands of the bus master
  typedef enum logic [1:0] {
    op_start = 2'h0,
    op_stop  = 2'h1,
    op_write = 2'h2,
    op_read  = 2'h3
  } twi_op_type;

endpackage

// ===== include/twi_bus_if.sv
// the two-wire bus between the master end and the display slave end
// both lines are open drain with a pull-up; this file resolves the wire levels
interface twi_bus_if;

  logic master_scl_o;
  logic master_scl_oe_n;
  logic master_sda_o;
  logic master_sda_oe_n;
  logic slave_sda_o;
  logic slave_sda_oe_n;
  logic scl;
  logic sda;

  // a line reads low only while an enabled driver pulls it low
  assign scl = master_scl_oe_n | master_scl_o;
  assign sda = (master_sda_oe_n | master_sda_o) & (slave_sda_oe_n | slave_sda_o);

  modport slave (
    input  scl, sda,
    output slave_sda_o, slave_sda_oe_n
  );

  modport master (
    input  scl, sda,
    output master_scl_o, master_scl_oe_n, master_sda_o, master_sda_oe_n
  );

endinterface

// ===== hw/twi_bus_master.sv
// byte-level master end of the two-wire bus: start, stop, write byte, read byte
// assumes a single slave side that never stretches scl
module twi_bus_master
  import twi_pkg::*;
#(
  parameter int QUARTER_CYCLES = SCL_QUARTER_CYCLES
)(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // two-wire bus
  twi_bus_if.master       bus,
  // command
  input  wire logic       cmd_valid,
  input  twi_op_type      cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_ack,
  output logic            cmd_ready,
  // response
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            rsp_nack
);

  if (QUARTER_CYCLES < 2) begin : check_quarter
    $error("QUARTER_CYCLES must be at least 2");
  end

  typedef enum logic [3:0] {
    m_idle  = 4'h1,
    m_start = 4'h2,
    m_bit   = 4'h4,
    m_stop  = 4'h8
  } master_state_type;

  master_state_type state;
  logic [15:0]      qcnt;
  logic [1:0]       phase;
  logic [3:0]       bit_cnt;
  logic [7:0]       shreg;
  logic             is_read;
  logic             ack_to_send;
  logic             bus_owned;
  logic             scl_oe_n;
  logic             sda_oe_n;
  logic             tick;
  logic             accept;

  // a fresh start only on an idle bus; a repeated start while we own it
  assign accept = cmd_valid & cmd_ready
                  & ((cmd_op != op_start) | bus_owned | (bus.scl & bus.sda));
  assign tick   = qcnt == 16'(QUARTER_CYCLES - 1);

  assign bus.master_scl_o    = 1'h0;
  assign bus.master_sda_o    = 1'h0;
  assign bus.master_scl_oe_n = scl_oe_n;
  assign bus.master_sda_oe_n = sda_oe_n;

  // quarter period timer, scl period is four quarters
  always_ff @(posedge ref_clk) begin
    if (reset || accept || tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  // data bits move sda only in phase 1, while scl is low; start and stop also move it in phase 3, while scl is high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state       <= m_idle;
      phase       <= 2'h0;
      bit_cnt     <= BIT_COUNT_ZERO;
      shreg       <= 8'h00;
      is_read     <= 1'h0;
      ack_to_send <= 1'h0;
      bus_owned   <= 1'h0;
      scl_oe_n    <= 1'h1;
      sda_oe_n    <= 1'h1;
      cmd_ready   <= 1'h1;
      rsp_valid   <= 1'h0;
      rsp_data    <= 8'h00;
      rsp_nack    <= 1'h0;
    end else begin
      rsp_valid <= 1'h0;
      case (state)
        m_idle: begin
          if (accept) begin
            cmd_ready   <= 1'h0;
            phase       <= 2'h0;
            bit_cnt     <= BIT_COUNT_ZERO;
            shreg       <= cmd_data;
            is_read     <= cmd_op == op_read;
            ack_to_send <= cmd_ack;
            case (cmd_op)
              op_start: state <= m_start;
              op_stop:  state <= m_stop;
              default:  state <= m_bit;
            endcase
          end
        end
        m_start, m_stop: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: scl_oe_n <= 1'h0;
              2'h1: sda_oe_n <= (state == m_stop) ? 1'h0 : 1'h1;
              2'h2: scl_oe_n <= 1'h1;
              default: begin
                sda_oe_n  <= (state == m_stop) ? 1'h1 : 1'h0;
                bus_owned <= state == m_start;
                state     <= m_idle;
                cmd_ready <= 1'h1;
                rsp_valid <= 1'h1;
              end
            endcase
          end
        end
        m_bit: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: scl_oe_n <= 1'h0;
              2'h1: begin
                if (bit_cnt == BITS_PER_BYTE) begin
                  // ninth pulse: reader acknowledges, last read byte gets none
                  sda_oe_n <= is_read ? ~ack_to_send : 1'h1;
                end else begin
                  sda_oe_n <= is_read ? 1'h1 : shreg[7];
                end
              end
              2'h2: scl_oe_n <= 1'h1;
              default: begin
                bit_cnt <= bit_cnt + BIT_COUNT_STEP;
                if (bit_cnt == BITS_PER_BYTE) begin
                  rsp_nack  <= bus.sda;
                  rsp_data  <= shreg;
                  state     <= m_idle;
                  cmd_ready <= 1'h1;
                  rsp_valid <= 1'h1;
                end else begin
                  shreg <= {shreg[6:0], bus.sda};
                end
              end
            endcase
          end
        end
        default: begin
          state     <= m_idle;
          cmd_ready <= 1'h1;
        end
      endcase
    end
  end

endmodule

// ===== tb/twi_link_properties.sv
// concurrent checks on the two-wire link between the master end and the display slave
// assumes the master runs at its default quarter period of eight ref_clk cycles
module twi_link_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // resolved link and slave drive
  input wire logic scl,
  input wire logic sda,
  input wire logic slave_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // scl rises since the last start, saturating so long transfers do not wrap
  logic [3:0] rise_cnt;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rise_cnt <= 4'h0;
    end else if (scl && $past(scl) && $past(sda) && !sda) begin
      rise_cnt <= 4'h0;
    end else if ($rose(scl) && rise_cnt != 4'hf) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  sequence start_seen;
    scl && $past(scl) && $past(sda) && !sda;
  endsequence
  sequence stop_seen;
    scl && $past(scl) && !$past(sda) && sda;
  endsequence
  sequence ack_begin;
    $fell(slave_sda_oe_n) && rise_cnt == 4'h8;
  endsequence

  slave_steady_high_a: assert property (scl && $past(scl) |-> $stable(slave_sda_oe_n))
    else $error("slave drive changed while scl high");
  data_stable_rise_a: assert property ($rose(scl) |-> $stable(sda))
    else $error("sda moved on the scl rise");
  start_release_a: assert property (start_seen |-> slave_sda_oe_n [*8])
    else $error("slave drives sda right after start");
  stop_release_a: assert property (stop_seen |-> slave_sda_oe_n [*8])
    else $error("slave drives sda right after stop");
  ack_after_byte_a: assert property ($fell(slave_sda_oe_n) |-> rise_cnt >= 4'h8)
    else $error("slave drove sda before a full address byte");
  ack_hold_a: assert property (ack_begin |-> !slave_sda_oe_n [*8])
    else $error("acknowledge released too early");
  // at eight cycles a quarter, scl comes back high fifteen cycles after the drive shows
  ack_pulse_a: assert property (ack_begin |-> ##[1:20] scl)
    else $error("no ninth scl pulse after acknowledge");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*5])
    else $error("scl high phase too short");
  scl_low_min_a: assert property ($fell(scl) |-> !scl [*5])
    else $error("scl low phase too short");
endmodule

// ===== tb/twi_display_slave_tb.sv
// self-checking bench: master end and display slave end joined by the link
// assumes the master runs at its default quarter period, as the checker counts expect;
// a faster scl would exceed the rated bus clock
module twi_display_slave_tb
  import twi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        reset;
  logic        cmd_valid;
  twi_op_type  cmd_op;
  logic [7:0]  cmd_data;
  logic        cmd_ack;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rsp_nack;
  logic        strap_segment_g_line;
  logic        strap_segment_f_line;
  logic [7:0]  read_data;
  logic [7:0]  reg_select;
  logic        select_strobe;
  logic [7:0]  data_byte;
  logic        data_strobe;
  logic        read_strobe;
  logic [6:0]  slave_addr;
  logic        addressed;
  int          err_count;
  int          num_checks;
  int          cycles = 0;
  int          sel_count = 0;
  int          data_count = 0;
  int          read_count = 0;
  int          seed;
  logic [6:0]  addr;
  logic [10:0] exp_q[$];
  logic [10:0] note;

  twi_bus_if bus ();

  twi_bus_master #(.QUARTER_CYCLES(SCL_QUARTER_CYCLES)) twi_bus_master_i (
    .ref_clk, .reset, .bus(bus), .cmd_valid, .cmd_op, .cmd_data, .cmd_ack,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_nack);

  twi_display_slave twi_display_slave_i (
    .ref_clk, .reset, .bus(bus), .strap_segment_g_line, .strap_segment_f_line,
    .read_data, .reg_select, .select_strobe, .data_byte, .data_strobe,
    .read_strobe, .slave_addr, .addressed);

  twi_link_properties twi_link_properties_i (
    .ref_clk, .reset, .scl(bus.scl), .sda(bus.sda), .slave_sda_oe_n(bus.slave_sda_oe_n));

  always #5 ref_clk = ~ref_clk;

  task automatic stop_test;
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // note kind: 0 start or stop, 1 ninth bit only, 2 ninth bit and read byte
  task automatic op(twi_op_type o, logic [7:0] d, logic [1:0] kind, logic nack);
    @(negedge ref_clk);
    cmd_valid = 1'h1;
    cmd_op = o;
    cmd_data = d;
    cmd_ack = ~nack;
    exp_q.push_back({kind, nack, read_data});
    @(posedge ref_clk);
    while (cmd_ready !== 1'h1) @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'h1) @(negedge ref_clk);
  endtask

  always @(negedge ref_clk) begin
    if (select_strobe === 1'h1) sel_count++;
    if (data_strobe === 1'h1) data_count++;
    if (read_strobe === 1'h1) read_count++;
    if (rsp_valid === 1'h1) begin
      note = exp_q.pop_front();
      if (note[10:9] != 2'h0) check("ninth bit", {7'h00, rsp_nack}, {7'h00, note[8]});
      if (note[10:9] == 2'h2) check("read byte", rsp_data, note[7:0]);
    end
  end

  // cuts a hang short at about twice the nine thousand cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    ref_clk = 1'h0;
    reset = 1'h1;
    cmd_valid = 1'h0;
    cmd_op = op_start;
    cmd_data = 8'h00;
    cmd_ack = 1'h0;
    strap_segment_g_line = 1'h0;
    strap_segment_f_line = 1'h0;
    read_data = 8'h00;
    err_count = 0;
    num_checks = 0;
    seed = 48;
    addr = DEFAULT_ADDR;
    repeat (16) @(negedge ref_clk);
    reset = 1'h0;
    check("own address", {1'h0, slave_addr}, {1'h0, DEFAULT_ADDR});
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        // supply loss: the slave forgets its address and must be set up again
        reset = 1'h1;
        repeat (2) @(negedge ref_clk);
        reset = 1'h0;
        check("own address", {1'h0, slave_addr}, {1'h0, DEFAULT_ADDR});
        addr = DEFAULT_ADDR;
      end
      // straps only move while the bus is idle, as a fixed strap would
      strap_segment_g_line = i[1];
      strap_segment_f_line = i[0];
      read_data = 8'($random(seed));
      op(op_start, 8'h00, 2'h0, 1'h0);
      op(op_write, {addr, 1'h0}, 2'h1, 1'h0);
      check("addressed", {7'h00, addressed}, 8'h01);
      op(op_write, SELF_ADDR_SELECT, 2'h1, 1'h0);
      op(op_write, read_data ^ 8'h5a, 2'h1, 1'h0);
      check("select word", reg_select, SELF_ADDR_SELECT);
      check("data byte", data_byte, read_data ^ 8'h5a);
      op(op_stop, 8'h00, 2'h0, 1'h0);
      addr = {ADDR_UPPER_ZERO, strap_segment_g_line, strap_segment_f_line};
      check("own address", {1'h0, slave_addr}, {1'h0, addr});
      op(op_start, 8'h00, 2'h0, 1'h0);
      op(op_write, {addr ^ 7'h40, 1'h0}, 2'h1, 1'h1);
      check("addressed", {7'h00, addressed}, 8'h00);
      op(op_start, 8'h00, 2'h0, 1'h0);
      op(op_write, {addr, DIR_READ}, 2'h1, 1'h0);
      op(op_read, 8'h00, 2'h2, 1'h0);
      // a fresh byte proves the second read takes read_data again
      read_data = 8'($random(seed));
      op(op_read, 8'h00, 2'h2, 1'h1);
      op(op_stop, 8'h00, 2'h0, 1'h0);
      check("addressed", {7'h00, addressed}, 8'h00);
      check("select strobes", 8'(sel_count), 8'(i + 1));
      check("data strobes", 8'(data_count), 8'(i + 1));
      check("read strobes", 8'(read_count), 8'(2 * i + 2));
    end
    stop_test();
  end
endmodule
